// ==== logic/limit_alert_pkg.sv ====
`default_nettype none
package limit_alert_pkg;
	localparam int DATA_W = 12;
	localparam int WADDR_W = 4;
	localparam int RADDR_W = 5;
	localparam int NUM_CH = 4;
	localparam int NUM_LIMITS = 8;

	// Register write addresses (read address is the same value, 5 bits)
	localparam logic [3:0] ADDR_ALERT = 4'h3;
	localparam logic [3:0] ADDR_AUX1_HI = 4'h4;
	localparam logic [3:0] ADDR_AUX1_LO = 4'h5;
	localparam logic [3:0] ADDR_BAT1_HI = 4'h6;
	localparam logic [3:0] ADDR_BAT1_LO = 4'h7;
	localparam logic [3:0] ADDR_BAT2_HI = 4'h8;
	localparam logic [3:0] ADDR_BAT2_LO = 4'h9;
	localparam logic [3:0] ADDR_TEMP_LO = 4'ha;
	localparam logic [3:0] ADDR_TEMP_HI = 4'hb;
	localparam logic [3:0] ADDR_SLAVE_SEQ = 4'hc;
	localparam logic [3:0] ADDR_MASTER_SEQ = 4'hd;
	localparam logic [3:0] ADDR_DAC = 4'he;

	// Reset values
	localparam logic [11:0] RST_ALERT = 12'h000;
	localparam logic [11:0] RST_LIMIT = 12'h000;
	localparam logic [11:0] RST_SEQ = 12'h000;
	localparam logic [11:0] RST_DAC = 12'h008;

	// Alert register fields
	localparam int ALERT_LO_POS = 0;
	localparam int ALERT_HI_POS = 4;
	localparam int ALERT_EN_POS = 8;

	// Output converter control fields
	localparam int DAC_RANGE_POS = 0;
	localparam int DAC_TYPE_POS = 2;
	localparam int DAC_PD_POS = 3;
	localparam int DAC_CODE_POS = 4;
	localparam int DAC_CODE_W = 8;

	// Converter channel codes of monitored channels
	localparam logic [3:0] CH_AUX1 = 4'h3;
	localparam logic [3:0] CH_BAT1 = 4'h6;
	localparam logic [3:0] CH_BAT2 = 4'h7;
	localparam logic [3:0] CH_TEMP1 = 4'h8;

	// Power management code that blocks the master sequence
	localparam logic [1:0] PM_ALWAYS_ON = 2'b10;

	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [11:0] data;
	} conv_result_t;

	typedef struct packed {
		logic en;
		logic [3:0] addr;
		logic [11:0] data;
	} reg_write_t;

	typedef struct packed {
		logic range_full;
		logic current_out;
		logic powerdown;
		logic [7:0] code;
	} dac_ctrl_t;
endpackage : limit_alert_pkg
`default_nettype wire

// ==== logic/limit_alert_sequence_dac_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module limit_alert_sequence_dac_regs #(
	parameter int DATA_W = limit_alert_pkg::DATA_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register access from the serial framing
	input wire limit_alert_pkg::reg_write_t reg_wr,
	input wire logic [4:0] rd_addr,
	output logic [11:0] rd_data,
	// Conversion results and power state
	input wire limit_alert_pkg::conv_result_t conv_in,
	input wire logic [1:0] adc_power_code,
	// Alert and sequencing
	output logic alert_out,
	output logic [11:0] slave_select,
	output logic [11:0] master_select,
	output logic master_seq_allowed,
	// Output converter control
	output var limit_alert_pkg::dac_ctrl_t dac_ctrl
);
	logic [11:0] alert_q;
	logic [11:0] alert_d;
	logic [DATA_W-1:0] limit_q [limit_alert_pkg::NUM_LIMITS];
	logic [11:0] slave_q;
	logic [11:0] master_q;
	logic [11:0] dac_q;
	logic [11:0] rd_data_q;
	logic [11:0] rd_data_d;
	logic alert_out_q;
	logic master_ok_q;
	logic [11:0] master_sel_q;

	// Write decode
	wire wr_alert = reg_wr.en && reg_wr.addr == limit_alert_pkg::ADDR_ALERT;
	wire wr_slave = reg_wr.en
		&& reg_wr.addr == limit_alert_pkg::ADDR_SLAVE_SEQ;
	wire wr_master = reg_wr.en
		&& reg_wr.addr == limit_alert_pkg::ADDR_MASTER_SEQ;
	wire wr_dac = reg_wr.en && reg_wr.addr == limit_alert_pkg::ADDR_DAC;
	wire wr_limit = reg_wr.en
		&& reg_wr.addr >= limit_alert_pkg::ADDR_AUX1_HI
		&& reg_wr.addr <= limit_alert_pkg::ADDR_TEMP_HI;
	wire [2:0] wr_limit_idx =
		3'(reg_wr.addr - limit_alert_pkg::ADDR_AUX1_HI);

	// Per-channel compare: limit slots and channel codes
	wire [3:0] ch_code [limit_alert_pkg::NUM_CH];
	wire [2:0] hi_idx [limit_alert_pkg::NUM_CH];
	wire [2:0] lo_idx [limit_alert_pkg::NUM_CH];
	assign ch_code[0] = limit_alert_pkg::CH_AUX1;
	assign ch_code[1] = limit_alert_pkg::CH_BAT1;
	assign ch_code[2] = limit_alert_pkg::CH_BAT2;
	assign ch_code[3] = limit_alert_pkg::CH_TEMP1;
	assign hi_idx[0] = 3'(limit_alert_pkg::ADDR_AUX1_HI - 4'h4);
	assign lo_idx[0] = 3'(limit_alert_pkg::ADDR_AUX1_LO - 4'h4);
	assign hi_idx[1] = 3'(limit_alert_pkg::ADDR_BAT1_HI - 4'h4);
	assign lo_idx[1] = 3'(limit_alert_pkg::ADDR_BAT1_LO - 4'h4);
	assign hi_idx[2] = 3'(limit_alert_pkg::ADDR_BAT2_HI - 4'h4);
	assign lo_idx[2] = 3'(limit_alert_pkg::ADDR_BAT2_LO - 4'h4);
	assign hi_idx[3] = 3'(limit_alert_pkg::ADDR_TEMP_HI - 4'h4);
	assign lo_idx[3] = 3'(limit_alert_pkg::ADDR_TEMP_LO - 4'h4);

	wire [3:0] set_lo;
	wire [3:0] set_hi;
	wire [3:0] ch_alarm;

	genvar c;
	generate
		for (c = 0; c < limit_alert_pkg::NUM_CH; c++) begin : g_ch
			wire hit = conv_in.valid && conv_in.chan == ch_code[c];
			wire [DATA_W-1:0] lo_lim = limit_q[lo_idx[c]];
			wire [DATA_W-1:0] hi_lim = limit_q[hi_idx[c]];
			if (c == 3) begin : g_temp
				// Temperature senses are inverted as the register defines
				assign set_lo[c] = hit && conv_in.data > lo_lim;
				assign set_hi[c] = hit && conv_in.data < hi_lim;
			end else begin : g_norm
				assign set_lo[c] = hit && conv_in.data < lo_lim;
				assign set_hi[c] = hit && conv_in.data > hi_lim;
			end
			// Channel drives alert only if enabled
			assign ch_alarm[c] = alert_q[limit_alert_pkg::ALERT_EN_POS + c]
				&& (alert_q[limit_alert_pkg::ALERT_LO_POS + c]
				|| alert_q[limit_alert_pkg::ALERT_HI_POS + c]);
		end
	endgenerate

	// Flag update: a set in the same cycle as a host write wins
	always_comb begin
		alert_d = wr_alert ? reg_wr.data : alert_q;
		alert_d[limit_alert_pkg::ALERT_LO_POS +: 4] =
			alert_d[limit_alert_pkg::ALERT_LO_POS +: 4] | set_lo;
		alert_d[limit_alert_pkg::ALERT_HI_POS +: 4] =
			alert_d[limit_alert_pkg::ALERT_HI_POS +: 4] | set_hi;
	end

	// Read mux, registered for the serial shifter
	always_comb begin
		rd_data_d = 12'h000;
		if (rd_addr[4] == 1'b0) begin
			unique case (rd_addr[3:0])
				limit_alert_pkg::ADDR_ALERT: rd_data_d = alert_q;
				limit_alert_pkg::ADDR_AUX1_HI,
				limit_alert_pkg::ADDR_AUX1_LO,
				limit_alert_pkg::ADDR_BAT1_HI,
				limit_alert_pkg::ADDR_BAT1_LO,
				limit_alert_pkg::ADDR_BAT2_HI,
				limit_alert_pkg::ADDR_BAT2_LO,
				limit_alert_pkg::ADDR_TEMP_LO,
				limit_alert_pkg::ADDR_TEMP_HI: begin
					rd_data_d = 12'(limit_q[3'(rd_addr[3:0] - 4'h4)]);
				end
				limit_alert_pkg::ADDR_SLAVE_SEQ: rd_data_d = slave_q;
				limit_alert_pkg::ADDR_MASTER_SEQ: rd_data_d = master_q;
				limit_alert_pkg::ADDR_DAC: rd_data_d = dac_q;
				default: rd_data_d = 12'h000;
			endcase
		end
	end

	wire master_ok = adc_power_code != limit_alert_pkg::PM_ALWAYS_ON;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			alert_q <= limit_alert_pkg::RST_ALERT;
		end else begin
			alert_q <= alert_d;
		end
	end

	generate
		for (c = 0; c < limit_alert_pkg::NUM_LIMITS; c++) begin : g_lim
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					limit_q[c] <= DATA_W'(limit_alert_pkg::RST_LIMIT);
				end else if (wr_limit && wr_limit_idx == 3'(c)) begin
					limit_q[c] <= DATA_W'(reg_wr.data);
				end
			end
		end
	endgenerate

	// Masks and control keep every bit, unused ones as storage
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			slave_q <= limit_alert_pkg::RST_SEQ;
			master_q <= limit_alert_pkg::RST_SEQ;
			dac_q <= limit_alert_pkg::RST_DAC;
		end else begin
			if (wr_slave) begin
				slave_q <= reg_wr.data;
			end
			if (wr_master) begin
				master_q <= reg_wr.data;
			end
			if (wr_dac) begin
				dac_q <= reg_wr.data;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_q <= 12'h000;
			alert_out_q <= 1'b0;
			master_ok_q <= 1'b0;
			master_sel_q <= 12'h000;
		end else begin
			rd_data_q <= rd_data_d;
			alert_out_q <= |ch_alarm;
			master_ok_q <= master_ok;
			master_sel_q <= master_ok ? master_q : 12'h000;
		end
	end

	assign rd_data = rd_data_q;
	assign alert_out = alert_out_q;
	assign slave_select = {slave_q[11:1], 1'b0};
	assign master_select = master_sel_q;
	assign master_seq_allowed = master_ok_q;
	wire dac_range = dac_q[limit_alert_pkg::DAC_RANGE_POS];
	wire dac_type = dac_q[limit_alert_pkg::DAC_TYPE_POS];
	wire dac_pd = dac_q[limit_alert_pkg::DAC_PD_POS];
	wire [7:0] dac_code = dac_q[limit_alert_pkg::DAC_CODE_POS +:
		limit_alert_pkg::DAC_CODE_W];
	assign dac_ctrl = '{dac_range, dac_type, dac_pd, dac_code};
endmodule : limit_alert_sequence_dac_regs
`default_nettype wire

// ==== tb/limit_alert_chk_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module limit_alert_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Observed ports
	input wire limit_alert_pkg::reg_write_t reg_wr,
	input wire logic [4:0] rd_addr,
	input wire logic [11:0] rd_data,
	input wire logic [1:0] adc_power_code,
	input wire logic alert_out,
	input wire logic [11:0] master_select,
	input wire logic [11:0] slave_select,
	input wire logic master_seq_allowed,
	input wire limit_alert_pkg::dac_ctrl_t dac_ctrl
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_dac_mode_bits: assert property (reg_wr.en && reg_wr.addr == 4'he |=>
		{dac_ctrl.range_full, dac_ctrl.current_out, dac_ctrl.powerdown} ==
		{$past(reg_wr.data[0]), $past(reg_wr.data[2]), $past(reg_wr.data[3])})
		else $error("dac mode bits wrong");
	a_dac_code_field: assert property (reg_wr.en && reg_wr.addr == 4'he |=>
		dac_ctrl.code == $past(reg_wr.data[11:4])) else $error("dac code wrong");
	a_dac_reset_off: assert property ($rose(resetn) |-> dac_ctrl.powerdown)
		else $error("dac not powered down");
	a_master_blocked: assert property (adc_power_code == 2'b10 |=>
		!master_seq_allowed && master_select == 12'h000) else $error("master ran");
	a_master_allowed: assert property (adc_power_code != 2'b10 |=>
		master_seq_allowed) else $error("master held off");
	a_slave_mask_write: assert property (reg_wr.en && reg_wr.addr == 4'hc |=>
		slave_select[11:1] == $past(reg_wr.data[11:1])) else $error("slave mask");
	a_unmapped_zero: assert property (rd_addr < 5'h03 || rd_addr > 5'h0e |=>
		rd_data == 12'h000) else $error("unmapped read not zero");
	a_alert_masked: assert property ((reg_wr.en && reg_wr.addr == 4'h3 &&
		reg_wr.data[11:8] == 4'h0) ##1 !reg_wr.en |=> !alert_out)
		else $error("alert with no enable");
	a_limit_readback: assert property ((reg_wr.en && reg_wr.addr == 4'h4)
		##1 !reg_wr.en ##1 rd_addr == 5'h04 |=> rd_data == $past(reg_wr.data, 3))
		else $error("limit readback");
endmodule : limit_alert_chk
bind limit_alert_sequence_dac_regs limit_alert_chk i_chk (.sys_clk(sys_clk),
	.resetn(resetn), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data),
	.adc_power_code(adc_power_code), .alert_out(alert_out),
	.master_select(master_select), .slave_select(slave_select),
	.master_seq_allowed(master_seq_allowed), .dac_ctrl(dac_ctrl));
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input wire logic sys_clk,
	// Register port
	output var limit_alert_pkg::reg_write_t reg_wr = '0,
	output var logic [4:0] rd_addr = 5'h00,
	input wire logic [11:0] rd_data
);
	task automatic wr(input logic [4:0] a, input logic [11:0] d);
		@(posedge sys_clk);
		reg_wr <= '{1'b1, a[3:0], d};
		@(posedge sys_clk);
		reg_wr.en <= 1'b0;
	endtask : wr
	// Address first, data one flop later
	task automatic rd(input logic [4:0] a, output logic [11:0] d);
		@(posedge sys_clk);
		rd_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1 d = rd_data;
	endtask : rd
endmodule : host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [4:0] a; logic [11:0] d; logic [11:0] e;} row_t;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] adc_power_code = 2'b00;
	limit_alert_pkg::conv_result_t conv_in = '0;
	limit_alert_pkg::reg_write_t reg_wr;
	limit_alert_pkg::dac_ctrl_t dac_ctrl;
	logic [4:0] rd_addr;
	logic [11:0] rd_data, v, slave_select, master_select;
	logic alert_out, master_seq_allowed;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	row_t rows [14] = '{'{5'h03, 12'h000, 12'h000}, '{5'h04, 12'h800, 12'h800},
		'{5'h05, 12'h100, 12'h100}, '{5'h06, 12'h800, 12'h800},
		'{5'h07, 12'h100, 12'h100}, '{5'h08, 12'h800, 12'h800},
		'{5'h09, 12'h100, 12'h100}, '{5'h0a, 12'h100, 12'h100},
		'{5'h0b, 12'h800, 12'h800}, '{5'h0c, 12'h555, 12'h555},
		'{5'h0d, 12'haaa, 12'haaa}, '{5'h0e, 12'h5a6, 12'h5a6},
		'{5'h02, 12'hfff, 12'h000}, '{5'h0f, 12'hfff, 12'h000}};
	limit_alert_sequence_dac_regs i_dut (.sys_clk(sys_clk), .resetn(resetn),
		.reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data), .conv_in(conv_in),
		.adc_power_code(adc_power_code), .alert_out(alert_out),
		.slave_select(slave_select), .master_select(master_select),
		.master_seq_allowed(master_seq_allowed), .dac_ctrl(dac_ctrl));
	host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .rd_addr(rd_addr),
		.rd_data(rd_data));
	always #5 sys_clk = ~sys_clk;
	task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic conv(input logic [3:0] c, input logic [11:0] d);
		@(posedge sys_clk);
		conv_in <= '{1'b1, c, d};
		@(posedge sys_clk);
		conv_in.valid <= 1'b0;
	endtask : conv
	task automatic conclude;
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			i_host.rd(rows[i].a, v);
			chk("reset", v, rows[i].a == 5'h0e ? 12'h008 : 12'h000);
			i_host.wr(rows[i].a, rows[i].d);
			i_host.rd(rows[i].a, v);
			chk("readback", v, rows[i].e);
		end
		chk("slave", slave_select, 12'h554);
		chk("master", master_select, 12'haaa);
		chk("dac", {1'b0, dac_ctrl}, 12'h25a);
		i_host.wr(5'h03, 12'h400);
		conv(4'h3, 12'h0ff);
		conv(4'h6, 12'h900);
		conv(4'h8, 12'h200);
		conv(4'h7, 12'h100);
		conv(4'h5, 12'h000);
		i_host.rd(5'h03, v);
		chk("flags", v, 12'h4a9);
		chk("alert masked", {11'h000, alert_out}, 12'h000);
		i_host.wr(5'h03, 12'h2a9);
		i_host.rd(5'h03, v);
		chk("alert on", {11'h000, alert_out}, 12'h001);
		i_host.wr(5'h03, 12'h000);
		i_host.rd(5'h03, v);
		chk("cleared", v, 12'h000);
		@(posedge sys_clk);
		adc_power_code <= 2'b10;
		repeat (2) @(posedge sys_clk);
		#1 chk("blocked", master_select, 12'h000);
		chk("allowed", {11'h000, master_seq_allowed}, 12'h000);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		i_host.rd(5'h0e, v);
		chk("dac reset", v, 12'h008);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
